// ===== rtl/i2cs_pkg.sv
// i2cs_pkg: register map, field positions and types of the i2c target
package i2cs_pkg;
  // ===========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EN = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;
  localparam logic [7:0] OFF_RAW = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_MSTAT = 8'h18;
  localparam logic [7:0] OFF_CLR_RD = 8'h1C;
  localparam logic [7:0] OFF_CLR_ABRT = 8'h20;
  localparam logic [7:0] OFF_CLR_OVER = 8'h24;
  localparam logic [7:0] OFF_STAT = 8'h28;
  localparam logic [7:0] OFF_RXTL = 8'h2C;
  // ===========================================================
  // field positions
  localparam int CTRL_ROLE = 0;
  localparam int CTRL_10B = 3;
  localparam int CTRL_OFF = 6;
  localparam int CMD_BIT = 8;
  localparam int RAW_RXOVER = 1;
  localparam int RAW_RXFULL = 2;
  localparam int RAW_RDREQ = 5;
  localparam int RAW_ABRT = 6;
  localparam int STAT_TFE = 2;
  localparam int STAT_RECEIVE_NOT_EMPTY_BIT = 3;
  // ===========================================================
  // reset values and constants
  localparam logic [6:0] CTRL_RST = 7'h00;
  localparam logic [9:0] ADDR_RST = 10'h055;
  localparam logic [6:0] MASK_RST = 7'h00;
  localparam logic [4:0] HDR10 = 5'h1E;
  localparam logic [3:0] NB_BYTE = 4'h8;
  // ===========================================================
  // types
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR2, ST_ACK, ST_RX,
    ST_TX_WAIT, ST_TX, ST_TX_ACK, ST_SKIP
  } i2cs_state_e;
  typedef struct packed {
    logic scl;
    logic sda;
  } i2cs_line_s;
endpackage : i2cs_pkg

// ===== rtl/i2cs_slave.sv
// i2cs_slave: apb-programmed i2c target engine with tx and rx fifos
// Behaviour
// (R1) software disables before reconfiguring, then enables
// (R2) answer the programmed 10-bit own address
// (R3) own address resets to 0x55
// (R4) control bit 3 picks 7 or 10-bit addressing
// (R5) target only when bit 6 and bit 0 zero
// (R6) own width independent of master width
// (R7) line synchronisers reset to one
// (R8) software enables target after lines settle
// (R9) ack read address, become transmitter
// (R10) read sets raw bit 5 regardless of mask
// (R11) software polls raw status when masked
// (R12) stale tx data at read: abort, flush
// (R13) abort holds tx flushed until clear read
// (R14) software writes data with command bit 0
// (R15) software clears request and abort flags
// (R16) master ends byte with restart or stop
// (R17) write address: receive bytes into rx fifo
// (R18) full rx: drop byte, still ack, overflow
// (R19) rx threshold sets bit 2, not-empty status
// (R20) software reads bytes from data bits 7:0
// (R21) ack with empty fifo: request again, wait
// (R22) keep sending while acked and data left
// (R23) nack with leftover bytes: discard, abort
// (R24) fsm flush flag clears the tx fifo
// (R25) never enable master and target together
// (R26) stretch scl while awaiting transmit data
//
// The placing of the registers and the APB register port are this design's own decisions.
module i2cs_slave
  import i2cs_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe
);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  // ===========================================================
  // line synchronisers and condition detect
  i2cs_line_s s1_q, s2_q, s3_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '1; // [R7]
      s2_q <= '1;
      s3_q <= '1;
    end
    else
    begin
      s1_q <= '{scl: scl_i, sda: sda_i}; // [R7]
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign scl_rise = s2_q.scl & ~s3_q.scl;
  assign scl_fall = ~s2_q.scl & s3_q.scl;
  assign start_det = s2_q.scl & s3_q.scl & s3_q.sda & ~s2_q.sda;
  assign stop_det = s2_q.scl & s3_q.scl & ~s3_q.sda & s2_q.sda;
  // ===========================================================
  // apb decode and configuration registers
  logic [6:0] ctrl_q, mask_q, raw;
  logic en_q, active, wr, rd_acc, hit, addr_wr_q;
  logic [9:0] addr_q;
  logic [AW-1:0] rxtl_q;
  assign wr = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  // target only with both role bits low and enabled
  assign active = en_q & ~ctrl_q[CTRL_OFF] & ~ctrl_q[CTRL_ROLE]; // [R5] [R1] [R25]
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  always_comb
  begin
    hit = 1'b1;
    if (paddr == OFF_CTRL || paddr == OFF_EN || paddr == OFF_ADDR)
      hit = 1'b1;
    else if (paddr == OFF_DATA || paddr == OFF_RAW || paddr == OFF_MASK)
      hit = 1'b1;
    else if (paddr == OFF_MSTAT || paddr == OFF_CLR_RD)
      hit = 1'b1;
    else if (paddr == OFF_CLR_ABRT || paddr == OFF_CLR_OVER)
      hit = 1'b1;
    else if (paddr == OFF_STAT || paddr == OFF_RXTL)
      hit = 1'b1;
    else
      hit = 1'b0;
  end
  // writable configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      en_q <= 1'b0;
      addr_q <= ADDR_RST; // [R3]
      mask_q <= MASK_RST;
      rxtl_q <= '0;
      addr_wr_q <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == OFF_CTRL)
        ctrl_q <= pwdata[6:0]; // [R4]
      else if (paddr == OFF_EN)
        en_q <= pwdata[0];
      else if (paddr == OFF_ADDR)
      begin
        addr_q <= pwdata[9:0]; // [R2]
        addr_wr_q <= 1'b1;
      end
      else if (paddr == OFF_MASK)
        mask_q <= pwdata[6:0];
      else if (paddr == OFF_RXTL)
        rxtl_q <= pwdata[AW-1:0];
    end
  end
  // ===========================================================
  // fifos
  logic [7:0] txm [DEPTH];
  logic [7:0] rxm [DEPTH];
  logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [AW:0] tx_cnt, rx_cnt;
  logic tx_push, tx_pop, tx_flush, rx_pop, rx_push;
  logic flush_q, abort_q, rxp_q;
  logic [7:0] rxb_q;
  // writes refused while abort stands; command bit must be 0
  assign tx_push = wr & (paddr == OFF_DATA) & ~pwdata[CMD_BIT]
    & ~abort_q & (tx_cnt != FULL) & active; // [R13] [R14]
  assign tx_flush = flush_q | abort_q | ~active; // [R24] [R13]
  assign rx_pop = rd_acc & (paddr == OFF_DATA) & (rx_cnt != '0);
  assign rx_push = rxp_q & (rx_cnt != FULL); // [R18]
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end
    else if (tx_flush)
    begin
      tx_wp <= '0; // [R24]
      tx_rp <= '0;
      tx_cnt <= '0;
    end
    else
    begin
      tx_wp <= tx_wp + AW'(tx_push);
      tx_rp <= tx_rp + AW'(tx_pop);
      tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end
    else if (!active)
    begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end
    else
    begin
      rx_wp <= rx_wp + AW'(rx_push); // [R17]
      rx_rp <= rx_rp + AW'(rx_pop);
      rx_cnt <= rx_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    end
  end
  // storage arrays
  always_ff @(posedge pclk)
  begin
    if (tx_push)
      txm[tx_wp] <= pwdata[7:0];
    if (rx_push)
      rxm[rx_wp] <= rxb_q;
  end
  // ===========================================================
  // target state machine
  i2cs_state_e st_q, nx_q;
  logic [3:0] nb_q;
  logic [7:0] sh_q;
  logic m10_q, ev_rd_q;
  wire [7:0] sh_in = {sh_q[6:0], s2_q.sda};
  assign tx_pop = (st_q == ST_TX_WAIT) & (tx_cnt != '0) & ~tx_flush;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_IDLE;
      nx_q <= ST_IDLE;
      nb_q <= '0;
      sh_q <= '0;
      m10_q <= 1'b0;
      ev_rd_q <= 1'b0;
      flush_q <= 1'b0;
      rxp_q <= 1'b0;
      rxb_q <= '0;
    end
    else
    begin
      ev_rd_q <= 1'b0;
      flush_q <= 1'b0;
      rxp_q <= 1'b0;
      if (!active)
      begin
        st_q <= ST_IDLE;
        m10_q <= 1'b0;
      end
      else if (start_det)
      begin
        st_q <= ST_ADDR; // [R16]
        nb_q <= '0;
      end
      else if (stop_det)
      begin
        st_q <= ST_IDLE; // [R16]
        m10_q <= 1'b0;
      end
      else
      begin
        case (st_q)
          ST_ADDR, ST_ADDR2, ST_RX:
          begin
            if (scl_rise)
            begin
              sh_q <= sh_in;
              nb_q <= nb_q + 4'h1;
            end
            else if (scl_fall && nb_q == NB_BYTE)
            begin
              nb_q <= '0;
              st_q <= ST_ACK;
              if (st_q == ST_RX)
              begin
                rxp_q <= 1'b1; // [R17] [R18]
                rxb_q <= sh_q;
                nx_q <= ST_RX;
              end
              else if (st_q == ST_ADDR2)
              begin
                m10_q <= (sh_q == addr_q[7:0]); // [R2]
                nx_q <= ST_RX;
                if (sh_q != addr_q[7:0])
                  st_q <= ST_SKIP;
              end
              // own width only, whatever the master uses
              else if (!ctrl_q[CTRL_10B]) // [R4] [R6]
              begin
                nx_q <= sh_q[0] ? ST_TX_WAIT : ST_RX; // [R9] [R17]
                if (sh_q[7:1] != addr_q[6:0])
                  st_q <= ST_SKIP;
              end
              else
              begin
                nx_q <= sh_q[0] ? ST_TX_WAIT : ST_ADDR2;
                if (sh_q[7:3] != HDR10 || sh_q[2:1] != addr_q[9:8]
                  || (sh_q[0] && !m10_q))
                  st_q <= ST_SKIP;
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              st_q <= nx_q;
              if (nx_q == ST_TX_WAIT)
              begin
                ev_rd_q <= 1'b1; // [R9] [R10]
                flush_q <= (tx_cnt != '0); // [R12]
              end
            end
          end
          ST_TX_WAIT:
          begin
            if (tx_pop)
            begin
              sh_q <= txm[tx_rp];
              nb_q <= '0;
              st_q <= ST_TX;
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              sh_q <= {sh_q[6:0], 1'b1};
              nb_q <= nb_q + 4'h1;
              if (nb_q == 4'h7)
              begin
                nb_q <= '0;
                st_q <= ST_TX_ACK;
              end
            end
          end
          ST_TX_ACK:
          begin
            if (scl_rise && s2_q.sda)
            begin
              st_q <= ST_SKIP;
              flush_q <= (tx_cnt != '0); // [R23]
            end
            else if (scl_rise)
              nb_q <= 4'h1;
            else if (scl_fall && nb_q == 4'h1)
            begin
              st_q <= ST_TX_WAIT; // [R22]
              ev_rd_q <= (tx_cnt == '0); // [R21]
            end
          end
          default:
            st_q <= st_q;
        endcase
      end
    end
  end
  // open-drain drive: ack, data zeros, clock stretch
  assign sda_oe = (st_q == ST_ACK) | ((st_q == ST_TX) & ~sh_q[7]);
  assign scl_oe = (st_q == ST_TX_WAIT); // [R26]
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  // ===========================================================
  // raw event flags, set wins over clear
  logic rd_req_q, rx_over_q, clr_rd, clr_abrt, clr_over;
  assign clr_rd = rd_acc & (paddr == OFF_CLR_RD); // [R15]
  assign clr_abrt = rd_acc & (paddr == OFF_CLR_ABRT); // [R15]
  assign clr_over = rd_acc & (paddr == OFF_CLR_OVER);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_req_q <= 1'b0;
      abort_q <= 1'b0;
      rx_over_q <= 1'b0;
    end
    else
    begin
      rd_req_q <= ev_rd_q | (rd_req_q & ~clr_rd); // [R10] [R21]
      abort_q <= flush_q | (abort_q & ~clr_abrt); // [R12] [R13]
      rx_over_q <= (rxp_q & ~rx_push) | (rx_over_q & ~clr_over); // [R18]
    end
  end
  always_comb
  begin
    raw = '0;
    raw[RAW_ABRT] = abort_q;
    raw[RAW_RDREQ] = rd_req_q;
    raw[RAW_RXFULL] = rx_cnt > {1'b0, rxtl_q}; // [R19]
    raw[RAW_RXOVER] = rx_over_q;
  end
  // ===========================================================
  // read data, captured in the setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= '0;
      if (paddr == OFF_CTRL)
        prdata[6:0] <= ctrl_q;
      else if (paddr == OFF_EN)
        prdata[0] <= en_q;
      else if (paddr == OFF_ADDR)
        prdata[9:0] <= addr_q;
      else if (paddr == OFF_DATA)
        prdata[7:0] <= (rx_cnt != '0) ? rxm[rx_rp] : 8'h00; // [R20]
      else if (paddr == OFF_RAW)
        prdata[6:0] <= raw; // [R10]
      else if (paddr == OFF_MASK)
        prdata[6:0] <= mask_q;
      else if (paddr == OFF_MSTAT)
        prdata[6:0] <= raw & mask_q;
      else if (paddr == OFF_CLR_RD)
        prdata[0] <= rd_req_q;
      else if (paddr == OFF_CLR_ABRT)
        prdata[0] <= abort_q;
      else if (paddr == OFF_CLR_OVER)
        prdata[0] <= rx_over_q;
      else if (paddr == OFF_STAT)
      begin
        prdata[STAT_RECEIVE_NOT_EMPTY_BIT] <= (rx_cnt != '0); // [R19]
        prdata[STAT_TFE] <= (tx_cnt == '0);
      end
      else if (paddr == OFF_RXTL)
        prdata[AW-1:0] <= rxtl_q;
    end
  end
  // ===========================================================
  // assertions
  property p_sync_follow;
    @(posedge pclk) disable iff (!presetn)
    s2_q.scl == $past(scl_i, 2);
  endproperty
  a_sync_follow: assert property (p_sync_follow) // [R7]
    else $error("scl synchroniser does not follow pin");
  property p_addr_rst;
    @(posedge pclk) disable iff (!presetn)
    !addr_wr_q |-> addr_q == ADDR_RST;
  endproperty
  a_addr_rst: assert property (p_addr_rst) // [R3]
    else $error("own address lost reset value");
  property p_rd_req;
    @(posedge pclk) disable iff (!presetn)
    ev_rd_q |=> rd_req_q;
  endproperty
  a_rd_req: assert property (p_rd_req) // [R10]
    else $error("read request raw flag not set");
  property p_stale_flush;
    @(posedge pclk) disable iff (!presetn)
    flush_q |=> abort_q && tx_cnt == '0;
  endproperty
  a_stale_flush: assert property (p_stale_flush) // [R12]
    else $error("flush did not abort and empty tx fifo");
  property p_abort_hold;
    @(posedge pclk) disable iff (!presetn)
    abort_q && !clr_abrt |=> abort_q && tx_cnt == '0;
  endproperty
  a_abort_hold: assert property (p_abort_hold) // [R13]
    else $error("tx fifo accepted data during abort");
  property p_stretch;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_TX_WAIT && tx_cnt == '0 |-> scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) // [R26]
    else $error("scl not stretched while waiting");
  property p_overflow;
    @(posedge pclk) disable iff (!presetn)
    rxp_q && rx_cnt == FULL && active
      |=> rx_over_q && $stable(rx_cnt) ##0 st_q == ST_ACK;
  endproperty
  a_overflow: assert property (p_overflow) // [R18]
    else $error("full rx fifo not flagged or byte nacked");
  property p_inactive;
    @(posedge pclk) disable iff (!presetn)
    !active |=> st_q == ST_IDLE && !sda_oe && !scl_oe;
  endproperty
  a_inactive: assert property (p_inactive) // [R5]
    else $error("target engine active while disabled");
  property p_ack_drive;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_ACK |-> sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) // [R9]
    else $error("address or data not acknowledged");
  c_read: cover property (@(posedge pclk) ev_rd_q ##[1:1000] tx_pop);
  c_write: cover property (@(posedge pclk) rx_push);
  c_abort: cover property (@(posedge pclk) flush_q);
endmodule : i2cs_slave

// ===== test/i2cs_master_model.sv
// i2cs_master_model: remote i2c bus master on open-drain lines
module i2cs_master_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe,
  output int hang
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // line control
  // both lines released, pull-ups give idle high
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    hang = 0;
  end
  // release scl and wait out target stretching
  task rise_scl;
    int i;
    scl_oe = 1'b0;
    i = 0;
    while (scl !== 1'b1 && i < 2000)
    begin
      #5;
      i++;
    end
    if (i >= 2000)
      hang++;
  endtask : rise_scl
  // one bit: data set mid low, sampled mid high
  task clk_bit(input logic b, output logic s);
    #12 sda_oe = ~b;
    #12 rise_scl();
    #12 s = sda;
    #12 scl_oe = 1'b1;
  endtask : clk_bit
  // start or repeated start: sda falls while scl high
  // entry tasks align to the falling clock edge, so no line change
  // ever races the target's rising-edge synchroniser
  task start;
    @(negedge clk);
    #12 sda_oe = 1'b0;
    #12 rise_scl();
    #12 sda_oe = 1'b1;
    #12 scl_oe = 1'b1;
  endtask : start
  // stop: sda rises while scl high, bus released
  task stop;
    @(negedge clk);
    #12 sda_oe = 1'b1;
    #12 rise_scl();
    #24 sda_oe = 1'b0;
    #48;
  endtask : stop
  // byte msb first, then the ninth bit
  task xfer(input logic [7:0] tx, input logic ackv,
            output logic [7:0] rx, output logic ack);
    @(negedge clk);
    for (int k = 7; k >= 0; k--)
      clk_bit(tx[k], rx[k]);
    clk_bit(ackv, ack);
  endtask : xfer
endmodule : i2cs_master_model

// ===== test/i2cs_slave_tb_top.sv
// i2cs_slave_tb_top: self-checking bench for the i2c target engine
module i2cs_slave_tb_top
  import i2cs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready, pslverr, scl_o, sda_o, err, ack;
  logic s_scl_oe, s_sda_oe, m_scl_oe, m_sda_oe;
  logic [7:0] rx;
  logic [7:0] d [0:7];
  logic [6:0] own;
  logic [9:0] a10;
  int hang;
  int n_mismatch = 0;
  int cmp_count = 0;
  integer seed = 32'hE9A15C30;
  // wired-and bus lines with pull-ups
  wire scl = ~(m_scl_oe | s_scl_oe);
  wire sda = ~(m_sda_oe | s_sda_oe);
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  // =====
  // design and remote master
  i2cs_slave #(.DEPTH(DEPTH), .AW(2)) i_i2cs_slave (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl), .sda_i(sda), .scl_o(scl_o),
    .scl_oe(s_scl_oe), .sda_o(sda_o), .sda_oe(s_sda_oe));
  i2cs_master_model i_i2cs_master_model (.clk(pclk), .scl(scl),
    .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .hang(hang));
  // =====
  // checking and bus tasks
  task complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // apb transfer: setup, then access until pready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      n_mismatch++;
      complete_run();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask : wr
  // disable, program, enable, let synchronisers settle
  task setup(input logic [7:0] c, input logic [9:0] a);
    wr(OFF_EN, 32'h0);
    wr(OFF_ADDR, {22'h0, a});
    wr(OFF_CTRL, {24'h0, c});
    wr(OFF_EN, 32'h1);
    repeat (6) @(posedge pclk);
  endtask : setup
  // first address byte expected on the wire
  function logic [7:0] abyte(input logic [9:0] a, input logic ten,
                             input logic rdn);
    return ten ? {HDR10, a[9:8], rdn} : {a[6:0], rdn};
  endfunction : abyte
  task send(input logic [7:0] b, input logic exp_ack);
    i_i2cs_master_model.xfer(b, 1'b1, rx, ack);
    chk({31'h0, ack}, {31'h0, exp_ack});
  endtask : send
  task recv(input logic ackv, input logic [7:0] e);
    i_i2cs_master_model.xfer(8'hFF, ackv, rx, ack);
    chk({24'h0, rx}, {24'h0, e});
  endtask : recv
  // hang guard
  initial
  begin
    #200000;
    n_mismatch++;
    complete_run();
  end
  // =====
  // main sequence
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_ADDR, ALL, 32'h55);
    rd(OFF_CTRL, ALL, 32'h0);
    rd(8'h3C, ALL, 32'h0);
    chk({31'h0, err}, 32'h1);
    own = 7'($random(seed));
    setup(8'h00, {3'h0, own});
    wr(OFF_RXTL, 32'h3);
    // receive one byte past the fifo depth
    i_i2cs_master_model.start();
    send(abyte({3'h0, own}, 1'b0, 1'b0), 1'b0);
    for (int k = 0; k <= DEPTH; k++)
    begin
      d[k] = 8'($random(seed));
      send(d[k], 1'b0);
    end
    i_i2cs_master_model.stop();
    rd(OFF_RAW, 32'h66, 32'h06);
    rd(OFF_STAT, 32'h8, 32'h8);
    rd(OFF_DATA, ALL, {24'h0, d[0]});
    rd(OFF_RAW, 32'h4, 32'h0);
    for (int k = 1; k < DEPTH; k++)
      rd(OFF_DATA, ALL, {24'h0, d[k]});
    rd(OFF_STAT, 32'h8, 32'h0);
    apb(1'b0, OFF_CLR_OVER, 32'h0);
    rd(OFF_RAW, 32'h2, 32'h0);
    // foreign address, then target switched off
    i_i2cs_master_model.start();
    send(abyte({3'h0, own ^ 7'h01}, 1'b0, 1'b0), 1'b1);
    i_i2cs_master_model.stop();
    for (int k = 0; k < 2; k++)
    begin
      setup(8'h40 | 8'(k), {3'h0, own});
      i_i2cs_master_model.start();
      send(abyte({3'h0, own}, 1'b0, 1'b0), 1'b1);
      i_i2cs_master_model.stop();
    end
    setup(8'h00, {3'h0, own});
    // read with request, stretch, bulk and nack
    i_i2cs_master_model.start();
    send(abyte({3'h0, own}, 1'b0, 1'b1), 1'b0);
    repeat (8) @(posedge pclk);
    chk({31'h0, s_scl_oe}, 32'h1);
    rd(OFF_RAW, 32'h60, 32'h20);
    rd(OFF_MSTAT, 32'h60, 32'h0);
    wr(OFF_MASK, 32'h20);
    rd(OFF_MSTAT, 32'h60, 32'h20);
    rd(OFF_RAW, 32'h60, 32'h20);
    apb(1'b0, OFF_CLR_RD, 32'h0);
    for (int k = 0; k < 4; k++)
      d[k] = 8'($random(seed));
    wr(OFF_DATA, {24'h0, d[0]});
    recv(1'b0, d[0]);
    repeat (8) @(posedge pclk);
    rd(OFF_RAW, 32'h20, 32'h20);
    apb(1'b0, OFF_CLR_RD, 32'h0);
    for (int k = 1; k < 4; k++)
      wr(OFF_DATA, {24'h0, d[k]});
    recv(1'b0, d[1]);
    rd(OFF_RAW, 32'h20, 32'h0);
    recv(1'b1, d[2]);
    i_i2cs_master_model.stop();
    rd(OFF_RAW, 32'h40, 32'h40);
    rd(OFF_STAT, 32'h4, 32'h4);
    wr(OFF_DATA, {24'h0, d[0]});
    rd(OFF_STAT, 32'h4, 32'h4);
    apb(1'b0, OFF_CLR_ABRT, 32'h0);
    wr(OFF_DATA, {23'h0, 1'b1, d[0]});
    rd(OFF_STAT, 32'h4, 32'h4);
    wr(OFF_DATA, {24'h0, d[0]});
    rd(OFF_STAT, 32'h4, 32'h0);
    // stale byte met by a new read request
    i_i2cs_master_model.start();
    send(abyte({3'h0, own}, 1'b0, 1'b1), 1'b0);
    repeat (8) @(posedge pclk);
    rd(OFF_RAW, 32'h60, 32'h60);
    rd(OFF_STAT, 32'h4, 32'h4);
    apb(1'b0, OFF_CLR_ABRT, 32'h0);
    apb(1'b0, OFF_CLR_RD, 32'h0);
    wr(OFF_DATA, {24'h0, d[3]});
    recv(1'b1, d[3]);
    i_i2cs_master_model.stop();
    // ten-bit target written by the master
    a10 = 10'($random(seed));
    setup(8'h08, a10);
    i_i2cs_master_model.start();
    send(abyte(a10, 1'b1, 1'b0), 1'b0);
    send(a10[7:0], 1'b0);
    send(d[1], 1'b0);
    // repeated start, ten-bit read of the same target
    i_i2cs_master_model.start();
    send(abyte(a10, 1'b1, 1'b1), 1'b0);
    apb(1'b0, OFF_CLR_RD, 32'h0);
    wr(OFF_DATA, {24'h0, d[2]});
    recv(1'b1, d[2]);
    i_i2cs_master_model.stop();
    rd(OFF_DATA, ALL, {24'h0, d[1]});
    chk(32'(hang), 32'h0);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    complete_run();
  end
endmodule : i2cs_slave_tb_top
